// ===== core/ccg_pkg.sv
// Operation
// - reset clears both clock registers; cpu runs main divided by 64
// - main source: divider bits 00=/64, 01=/16, 10=/8, 11=/4
// - subsystem source ignores divider bits; cpu clock is subsystem/4
// - bit3 stop, bit2 halt; set by instruction, cleared by release
// - nibble write updates divider bits only, forces standby bits to zero
// - stop accepted only on main clock; halt works on either
// - system register bit0 selects subsystem, bit3 stops main oscillator
// - oscillator stop acts only while running on subsystem clock
// - stop bit set ties main oscillator input to ground
// - subsystem oscillator is never stopped
// - peripheral clocks divide main clock; only watch timer gets subsystem
// - stop mode ties main oscillator input to ground
// - standby instructions and bit accesses ignore memory bank enable flag
// - subsystem 32.768 kHz gives 122 us machine cycle via /4
// - previous clock keeps running some machine cycles after rewrite
package ccg_pkg;
   localparam logic [11:0] PROC_CLK_CTRL_ADDR = 12'hFB3;
   localparam logic [11:0] SYS_CLK_CTRL_ADDR = 12'hFB7;
   localparam logic [3:0] PROC_CLK_CTRL_RESET = 4'h0;
   localparam logic [3:0] SYS_CLK_CTRL_RESET = 4'h0;
   localparam int STOP_BIT_POS = 3;
   localparam int HALT_BIT_POS = 2;
   localparam int SUBSYS_SEL_POS = 0;
   localparam int OSC_STOP_POS = 3;
   localparam int PERIPH_DIV_WIDTH = 8;
   localparam logic [5:0] DIV64_HALF = 6'h1F;
   localparam logic [5:0] DIV16_HALF = 6'h07;
   localparam logic [5:0] DIV8_HALF = 6'h03;
   localparam logic [5:0] DIV4_HALF = 6'h01;
   localparam logic [5:0] SUB_DIV4_HALF = 6'h01;
   localparam logic [2:0] SWITCH_SETTLE_CYCLES = 3'h3;
endpackage

// ===== core/ccg_div.sv
`timescale 1ns/1ns
// divides an enable stream; tick output lasts one cycle per period
module ccg_div #(
   parameter int WIDTH = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick_in,
   input wire logic [WIDTH-1:0] half,
   output logic tick_out,
   output logic phase
);
   logic [WIDTH-1:0] cnt_q;
   // count ticks; toggle phase at half period boundary
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         phase <= 1'b0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if (cnt_q >= half) begin
               cnt_q <= '0;
               phase <= ~phase;
               tick_out <= phase; // falling edge of phase ends a period
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule

// ===== core/ccg_top.sv
`timescale 1ns/1ns
module ccg_top (
   clk,
   rst_n,
   main_osc_in,
   subsys_osc_in,
   wr_en,
   rd_en,
   addr,
   wr_data,
   bit_wr,
   bit_sel,
   bit_val,
   stop_instr,
   halt_instr,
   standby_release,
   rd_data,
   cpu_clk,
   cpu_cycle_tick,
   stop_request_bit,
   halt_request_bit,
   main_osc_input_gnd,
   main_osc_running,
   periph_clk,
   watch_clk,
   on_subsystem
);
   input wire logic clk;
   input wire logic rst_n;
   input wire logic main_osc_in;
   input wire logic subsys_osc_in;
   input wire logic wr_en;
   input wire logic rd_en;
   input wire logic [11:0] addr;
   input wire logic [3:0] wr_data;
   input wire logic bit_wr;
   input wire logic [1:0] bit_sel;
   input wire logic bit_val;
   input wire logic stop_instr;
   input wire logic halt_instr;
   input wire logic standby_release;
   output logic [3:0] rd_data;
   output logic cpu_clk;
   output logic cpu_cycle_tick;
   output logic stop_request_bit;
   output logic halt_request_bit;
   output logic main_osc_input_gnd;
   output logic main_osc_running;
   output logic [7:0] periph_clk;
   output logic watch_clk;
   output logic on_subsystem;

   ////////////////////////////////////////////////////////////////////
   // oscillator inputs come from pins: two flops, then edge detect
   logic [1:0] main_sync_q;
   logic [1:0] sub_sync_q;
   logic main_prev_q;
   logic sub_prev_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main_sync_q <= 2'h0;
         sub_sync_q <= 2'h0;
         main_prev_q <= 1'b0;
         sub_prev_q <= 1'b0;
      end else begin
         main_sync_q <= {main_sync_q[0], main_osc_in};
         sub_sync_q <= {sub_sync_q[0], subsys_osc_in};
         main_prev_q <= main_sync_q[1];
         sub_prev_q <= sub_sync_q[1];
      end
   end

   logic osc_stop_q;
   logic stop_q;
   // main ticks die while grounded by stop bit or stop mode
   wire main_tick = main_sync_q[1] & ~main_prev_q & ~osc_stop_q & ~stop_q;
   // subsystem has no gate at all
   wire sub_tick = sub_sync_q[1] & ~sub_prev_q;

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [1:0] div_sel_q;
   logic halt_q;
   logic sub_sel_q;
   // bank enable flag is not an input: addresses are absolute
   wire proc_wr = wr_en && addr == ccg_pkg::PROC_CLK_CTRL_ADDR;
   wire sys_bit_wr = bit_wr && addr == ccg_pkg::SYS_CLK_CTRL_ADDR;
   wire sel_wr = sys_bit_wr && bit_sel == 2'(ccg_pkg::SUBSYS_SEL_POS);
   wire ostop_wr = sys_bit_wr && bit_sel == 2'(ccg_pkg::OSC_STOP_POS);

   // divider bits; any code accepted, 01 on subsystem is software's job
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_sel_q <= ccg_pkg::PROC_CLK_CTRL_RESET[1:0];
      end else if (proc_wr) begin
         div_sel_q <= wr_data[1:0];
      end
   end

   // standby bits: instruction sets, release or nibble write clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_q <= ccg_pkg::PROC_CLK_CTRL_RESET[ccg_pkg::STOP_BIT_POS];
         halt_q <= ccg_pkg::PROC_CLK_CTRL_RESET[ccg_pkg::HALT_BIT_POS];
      end else begin
         if (stop_instr && !on_subsystem) begin
            stop_q <= 1'b1;
         end else if (standby_release || proc_wr) begin
            stop_q <= 1'b0;
         end
         if (halt_instr) begin
            halt_q <= 1'b1;
         end else if (standby_release || proc_wr) begin
            halt_q <= 1'b0;
         end
      end
   end

   // single-bit accesses, one bit per access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sub_sel_q <= ccg_pkg::SYS_CLK_CTRL_RESET[ccg_pkg::SUBSYS_SEL_POS];
         osc_stop_q <= ccg_pkg::SYS_CLK_CTRL_RESET[ccg_pkg::OSC_STOP_POS];
      end else begin
         if (sel_wr) begin
            sub_sel_q <= bit_val;
         end
         if (ostop_wr) begin
            // only takes effect once running from subsystem
            osc_stop_q <= bit_val & on_subsystem;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // cpu dividers
   logic main_cpu_tick;
   logic main_phase;
   logic sub_cpu_tick;
   logic sub_phase;
   logic [1:0] act_div_q;
   logic [5:0] main_half;
   always_comb begin
      case (act_div_q)
         2'h0: main_half = ccg_pkg::DIV64_HALF;
         2'h1: main_half = ccg_pkg::DIV16_HALF;
         2'h2: main_half = ccg_pkg::DIV8_HALF;
         2'h3: main_half = ccg_pkg::DIV4_HALF;
         default: main_half = ccg_pkg::DIV64_HALF;
      endcase
   end

   ccg_div #(.WIDTH(6)) u_main_div (
      .clk(clk),
      .rst_n(rst_n),
      .tick_in(main_tick),
      .half(main_half),
      .tick_out(main_cpu_tick),
      .phase(main_phase)
   );
   // subsystem /4: 32.768 kHz gives 122 us cycle
   ccg_div #(.WIDTH(6)) u_sub_div (
      .clk(clk),
      .rst_n(rst_n),
      .tick_in(sub_tick),
      .half(ccg_pkg::SUB_DIV4_HALF),
      .tick_out(sub_cpu_tick),
      .phase(sub_phase)
   );

   ////////////////////////////////////////////////////////////////////
   // switch-over: new setting waits for settle cycles, then a period end
   typedef enum logic [1:0] {CCG_RUN, CCG_SETTLE, CCG_SWAP} ccg_sw_e;
   ccg_sw_e sw_q;
   logic [2:0] settle_q;
   wire cur_tick = on_subsystem ? sub_cpu_tick : main_cpu_tick;
   wire pending = (sub_sel_q != on_subsystem) || (div_sel_q != act_div_q);
   // period end of the source being switched to
   wire new_tick = sub_sel_q ? sub_cpu_tick : main_cpu_tick;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_q <= CCG_RUN;
         settle_q <= 3'h0;
         on_subsystem <= ccg_pkg::SYS_CLK_CTRL_RESET[ccg_pkg::SUBSYS_SEL_POS];
         act_div_q <= ccg_pkg::PROC_CLK_CTRL_RESET[1:0];
      end else begin
         case (sw_q)
            CCG_RUN: begin
               if (pending) begin
                  sw_q <= CCG_SETTLE;
                  settle_q <= 3'h0;
               end
            end
            CCG_SETTLE: begin
               // old clock keeps running a few machine cycles
               if (cur_tick) begin
                  if (settle_q == ccg_pkg::SWITCH_SETTLE_CYCLES) begin
                     sw_q <= CCG_SWAP;
                  end else begin
                     settle_q <= settle_q + 3'h1;
                  end
               end
            end
            CCG_SWAP: begin
               // divider change lands right after a completed period; a source
               // change also waits for the new source's period end, cpu_clk held
               // low in between, so no runt pulse escapes either way
               if (sub_sel_q == on_subsystem || new_tick) begin
                  on_subsystem <= sub_sel_q;
                  act_div_q <= div_sel_q;
                  sw_q <= CCG_RUN;
               end
            end
            default: sw_q <= CCG_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all registered
   logic [ccg_pkg::PERIPH_DIV_WIDTH-1:0] pdiv_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clk <= 1'b0;
         cpu_cycle_tick <= 1'b0;
         pdiv_q <= '0;
         periph_clk <= 8'h00;
         watch_clk <= 1'b0;
         rd_data <= 4'h0;
         main_osc_input_gnd <= 1'b0;
         main_osc_running <= 1'b1;
      end else begin
         // held low while waiting for a new source: a longer low, never a runt
         cpu_clk <= (sw_q != CCG_SWAP) && (on_subsystem ? sub_phase : main_phase);
         cpu_cycle_tick <= cur_tick && sw_q != CCG_SWAP;
         // peripherals run from main clock only
         if (main_tick) begin
            pdiv_q <= pdiv_q + 1'b1;
         end
         periph_clk <= pdiv_q;
         watch_clk <= sub_sync_q[1];
         main_osc_input_gnd <= osc_stop_q | stop_q;
         main_osc_running <= ~(osc_stop_q | stop_q);
         if (rd_en && addr == ccg_pkg::PROC_CLK_CTRL_ADDR) begin
            rd_data <= {stop_q, halt_q, div_sel_q};
         end else if (rd_en && addr == ccg_pkg::SYS_CLK_CTRL_ADDR) begin
            rd_data <= {osc_stop_q, 2'h0, sub_sel_q};
         end else begin
            rd_data <= 4'h0;
         end
      end
   end

   assign stop_request_bit = stop_q;
   assign halt_request_bit = halt_q;
endmodule

// ===== testbench/ccg_assertions.sv
`timescale 1ns/1ns
module ccg_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [11:0] addr,
   input wire logic bit_wr,
   input wire logic [1:0] bit_sel,
   input wire logic bit_val,
   input wire logic stop_instr,
   input wire logic halt_instr,
   input wire logic standby_release,
   input wire logic cpu_cycle_tick,
   input wire logic stop_request_bit,
   input wire logic halt_request_bit,
   input wire logic main_osc_input_gnd,
   input wire logic main_osc_running,
   input wire logic on_subsystem
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   // standby bits, oscillator grounding and cpu tick width
   osc_inverse_a: assert property (main_osc_running == !main_osc_input_gnd)
      else $error("oscillator running flag not inverse of ground");
   halt_set_a: assert property (halt_instr |=> halt_request_bit)
      else $error("halt request not set");
   stop_set_a: assert property (stop_instr && !on_subsystem |=> stop_request_bit)
      else $error("stop request not set on main clock");
   stop_refused_a: assert property (stop_instr && on_subsystem && !stop_request_bit
      |=> !stop_request_bit) else $error("stop accepted on subsystem clock");
   release_clear_a: assert property (standby_release && !halt_instr && !stop_instr
      |=> !halt_request_bit && !stop_request_bit) else $error("release left standby bit");
   nibble_clear_a: assert property (wr_en && addr == ccg_pkg::PROC_CLK_CTRL_ADDR
      && !halt_instr && !stop_instr |=> !halt_request_bit && !stop_request_bit)
      else $error("nibble write kept standby bit");
   stop_ground_a: assert property (stop_request_bit |=> main_osc_input_gnd)
      else $error("stop mode did not ground oscillator input");
   tick_pulse_a: assert property (cpu_cycle_tick |=> !cpu_cycle_tick)
      else $error("cpu tick longer than one cycle");
   osc_main_block_a: assert property (bit_wr && addr == ccg_pkg::SYS_CLK_CTRL_ADDR
      && bit_sel == 2'h3 && !on_subsystem && !stop_request_bit && !stop_instr
      |-> ##2 !main_osc_input_gnd) else $error("oscillator stopped on main clock");
   // main scenarios reached
   cover property (halt_instr && standby_release);
   cover property (on_subsystem && cpu_cycle_tick);
   cover property (main_osc_input_gnd && on_subsystem);
endmodule
bind ccg_top ccg_assertions ccg_assertions_i (.clk, .rst_n, .wr_en, .addr, .bit_wr,
   .bit_sel, .bit_val, .stop_instr, .halt_instr, .standby_release, .cpu_cycle_tick,
   .stop_request_bit, .halt_request_bit, .main_osc_input_gnd, .main_osc_running,
   .on_subsystem);

// ===== testbench/tb.sv
`timescale 1ns/1ns
module tb;
   logic clk, rst_n, main_osc_in, subsys_osc_in, wr_en, rd_en, bit_wr, bit_val;
   logic stop_instr, halt_instr, standby_release, cpu_cycle_tick, stop_request_bit;
   logic halt_request_bit, main_osc_input_gnd, main_osc_running, on_subsystem;
   logic [11:0] addr;
   logic [3:0] wr_data, rd_data;
   logic [1:0] bit_sel;
   logic cpu_clk, watch_clk, w;
   logic [7:0] periph_clk, v;
   int n_fail = 0, samples_checked = 0, cycles = 0, p4, p;
   // oscillator pin periods below, in clk cycles
   localparam int MAIN_OSC_CYC = 4;
   localparam int SUB_OSC_CYC = 16;
   ccg_top ccg_top_i (.clk, .rst_n, .main_osc_in, .subsys_osc_in, .wr_en, .rd_en, .addr,
      .wr_data, .bit_wr, .bit_sel, .bit_val, .stop_instr, .halt_instr, .standby_release,
      .rd_data, .cpu_clk, .cpu_cycle_tick, .stop_request_bit, .halt_request_bit,
      .main_osc_input_gnd, .main_osc_running, .periph_clk, .watch_clk, .on_subsystem);
   ////////////////////////////////////////////////////////////////
   // clocks; oscillators toggle off the clock edges to avoid races
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      main_osc_in = 1'b0;
      #5;
      forever #8 main_osc_in = ~main_osc_in;
   end
   initial begin
      subsys_osc_in = 1'b0;
      #7;
      forever #32 subsys_osc_in = ~subsys_osc_in;
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////
   task conclude;
      $display("checks %0d errors %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // each access ends with an idle cycle so strobes never re-rise in one step
   task rd(input logic [11:0] a, input logic [3:0] e);
      addr = a;
      rd_en = 1'b1;
      cyc(1);
      rd_en = 1'b0;
      chk(rd_data, e);
      cyc(1);
   endtask
   task wr(input logic [3:0] d);
      addr = ccg_pkg::PROC_CLK_CTRL_ADDR;
      wr_data = d;
      wr_en = 1'b1;
      cyc(1);
      wr_en = 1'b0;
      cyc(1);
   endtask
   // one system register bit per access, never two at once
   task bw(input logic [1:0] s, input logic v);
      addr = ccg_pkg::SYS_CLK_CTRL_ADDR;
      bit_sel = s;
      bit_val = v;
      bit_wr = 1'b1;
      cyc(1);
      bit_wr = 1'b0;
      cyc(1);
   endtask
   task ins(input logic [2:0] v);
      {stop_instr, halt_instr, standby_release} = v;
      cyc(1);
      {stop_instr, halt_instr, standby_release} = 3'h0;
      cyc(1);
   endtask
   // cycles between two cpu ticks, bounded
   task per(output int q);
      int c;
      c = 0;
      while (cpu_cycle_tick !== 1'b1 && c < 3000) begin
         cyc(1);
         c++;
      end
      cyc(1);
      q = 1;
      while (cpu_cycle_tick !== 1'b1 && q < 3000) begin
         cyc(1);
         q++;
      end
   endtask
   // high time of cpu_clk in cycles, bounded
   task hi(output int q);
      int c;
      c = 0;
      while (cpu_clk !== 1'b0 && c < 3000) begin
         cyc(1);
         c++;
      end
      while (cpu_clk !== 1'b1 && c < 6000) begin
         cyc(1);
         c++;
      end
      q = 0;
      while (cpu_clk === 1'b1 && q < 3000) begin
         cyc(1);
         q++;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_reset;
      rd(ccg_pkg::PROC_CLK_CTRL_ADDR, 4'h0);
      rd(ccg_pkg::SYS_CLK_CTRL_ADDR, 4'h0);
      rd(12'hFB0, 4'h0);
      chk({on_subsystem, main_osc_running}, 2'h1);
   endtask
   // fastest first; periods follow from the main pin period and the divisor
   task t_div;
      int f [4] = '{64, 16, 8, 4};
      for (int k = 3; k >= 0; k--) begin
         wr(4'hC | 4'(k));
         rd(ccg_pkg::PROC_CLK_CTRL_ADDR, 4'(k));
         cyc(1300);
         per(p);
         if (k == 3)
            p4 = p;
         chk(16'(p), 16'(MAIN_OSC_CYC * f[k]));
         hi(p);
         chk(16'(p), 16'(MAIN_OSC_CYC * f[k] / 2));
         v = periph_clk;
         cyc(8);
         chk(8'(periph_clk - v), 16'h2);
      end
      chk(16'(p4), 16'(MAIN_OSC_CYC * 4));
   endtask
   task t_standby;
      ins(3'b010);
      chk(halt_request_bit, 1'b1);
      wr(4'h0);
      chk(halt_request_bit, 1'b0);
      ins(3'b011);
      chk(halt_request_bit, 1'b1);
      ins(3'b001);
      chk(halt_request_bit, 1'b0);
      ins(3'b100);
      chk({stop_request_bit, main_osc_input_gnd}, 2'h3);
      v = periph_clk;
      cyc(12);
      chk(16'(periph_clk), 16'(v));
      ins(3'b001);
      chk({stop_request_bit, main_osc_input_gnd}, 2'h0);
      bw(2'h3, 1'b1);
      chk(main_osc_input_gnd, 1'b0);
      rd(ccg_pkg::SYS_CLK_CTRL_ADDR, 4'h0);
   endtask
   task t_sub;
      wr(4'h2);
      bw(2'h0, 1'b1);
      p = 0;
      while (on_subsystem !== 1'b1 && p < 3000) begin
         cyc(1);
         p++;
      end
      chk(on_subsystem, 1'b1);
      cyc(400);
      per(p);
      chk(16'(p), 16'(SUB_OSC_CYC * 4));
      hi(p);
      chk(16'(p), 16'(SUB_OSC_CYC * 2));
      ins(3'b100);
      chk(stop_request_bit, 1'b0);
      ins(3'b010);
      chk(halt_request_bit, 1'b1);
      ins(3'b001);
      bw(2'h3, 1'b1);
      chk({main_osc_input_gnd, main_osc_running}, 2'h2);
      v = periph_clk;
      w = watch_clk;
      cyc(8);
      chk(16'(periph_clk), 16'(v));
      chk(16'(watch_clk), 16'(!w));
      rd(ccg_pkg::SYS_CLK_CTRL_ADDR, 4'h9);
      bw(2'h3, 1'b0);
      bw(2'h0, 1'b0);
      chk(main_osc_input_gnd, 1'b0);
   endtask
   // reset held six cycles, then the scenarios in turn
   initial begin
      {rst_n, wr_en, rd_en, bit_wr, bit_val, stop_instr, halt_instr, standby_release} = 8'h0;
      addr = 12'h000;
      wr_data = 4'h0;
      bit_sel = 2'h0;
      cyc(6);
      rst_n = 1'b1;
      cyc(1);
      t_reset();
      t_div();
      t_standby();
      t_sub();
      conclude();
   end
endmodule
